/* File: logic/tcc_timer.sv */
// Notes on behaviour
// - 16-bit up-counter, free-running or restarting at the modulo value.
// - terminal count comes from the software-written modulo register.
// - counter reads never disturb or pause counting.
// - two channels, each input capture or output compare.
// - counter clock: seven bus clock divisions or external clock pin.
// - three-bit prescale select field picks the counter clock.
// - active capture edge copies counter into the channel value.
// - capture edge selectable: rising, falling or either.
// - compare equality sets, clears or toggles the channel pin.
// - capture and compare events can request interrupts.
// - any channel pin optionally toggles on each overflow.
// - controls to halt the counter and to reset it.
// - unbuffered value writes take effect at once; equality only.
// - unsynchronised unbuffered changes may misbehave two periods.
// - buffered select links channels 0 and 1 onto channel-0 pin.
// - linked: channel 0 first, then last written pair per overflow.
// - linked: channel-0 control governs, channel-1 control ignored.
// - linked: channel-1 pin released for general use.
// - overflow flag set at modulo; interrupt only if enabled.
// - channel flag set per event; interrupt only if enabled.
// - buffered select wins over unbuffered select.
//
// The placing of the registers and the APB register port were decided locally.
module tcc_timer
	import tcc_pkg::*;
#(
	parameter int CW = 16
) (
	input  wire logic        CORE_CLK_I,
	input  wire logic        SRST_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic [31:0]      PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        EXT_TIMER_CLOCK_PIN_I,
	input  wire logic        CHAN0_PIN_I,
	output logic             CHAN0_PIN_O,
	output logic             CHAN0_PIN_OE_O,
	input  wire logic        CHAN1_PIN_I,
	output logic             CHAN1_PIN_O,
	output logic             CHAN1_PIN_OE_O,
	output logic             OVF_IRQ_O,
	output logic             CHAN0_IRQ_O,
	output logic             CHAN1_IRQ_O
);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] mod_r;
	logic [CW-1:0] cval_r [2];
	logic [7:0]    csc_r [2];
	logic [2:0]    prescale_select_r;
	logic          stop_r;
	logic          ovf_flag_r;
	logic          ovf_ie_r;
	logic          cnt_clr;
	logic          tick;
	logic          ovf_pulse_r;
	logic          upd_r;
	tcc_buf_e      buf_act_r;
	tcc_buf_e      buf_last_r;
	logic          linked;
	logic [1:0]    is_cmp;
	logic [1:0]    ch_en;
	logic [1:0]    ch_evt;
	logic [1:0]    ch_pin;
	logic [1:0]    ch_flag_r;
	logic [CW-1:0] ch_val [2];
	logic          wr_en;
	logic          rd_setup;
	logic [31:0]   rd_mux;
	logic          addr_ok;

	// bus decode: write lands only at the access edge with ready high
	assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
	assign rd_setup = PSEL_I & ~PENABLE_I;
	assign cnt_clr  = wr_en && (PADDR_I == TCC_OFF_TSC) &&
	                  PWDATA_I[TSC_CNT_RST];

	// buffered select outranks unbuffered select on channel 0
	assign linked = csc_r[0][CSC_BUF_SEL];

	// channel 1 control is ignored and the channel idles when linked
	assign ch_en[0] = 1'b1;
	assign ch_en[1] = ~linked;
	assign is_cmp[0] = tcc_is_compare(csc_r[0][CSC_BUF_SEL],
	                                  csc_r[0][CSC_UNBUF_SEL]);
	assign is_cmp[1] = tcc_is_compare(1'b0, csc_r[1][CSC_UNBUF_SEL]);

	// channel 0 compares against whichever linked pair is active
	assign ch_val[0] = (linked && buf_act_r == TCC_BUF_CH1) ?
	                   cval_r[1] : cval_r[0];
	assign ch_val[1] = cval_r[1];

	// counter clock source: bus clock division or external pin
	tcc_prescaler u_presc (
		.clk_i     (CORE_CLK_I),
		.srst_i    (SRST_I),
		.clr_i     (cnt_clr),
		.run_i     (~stop_r),
		.sel_i     (prescale_select_r),
		.ext_clk_i (EXT_TIMER_CLOCK_PIN_I),
		.tick_o    (tick)
	);

	// counter; reads never touch it, so counting is undisturbed
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I || cnt_clr) begin
			cnt_r <= '0;
		end else if (tick && !stop_r) begin
			if (cnt_r == mod_r) begin
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	// overflow pulse with the wrap; update pulse once the new count stands
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I || cnt_clr) begin
			ovf_pulse_r <= 1'b0;
			upd_r       <= 1'b0;
		end else begin
			ovf_pulse_r <= tick && !stop_r && (cnt_r == mod_r);
			upd_r       <= tick && !stop_r;
		end
	end

	// channel pins, events, compare and capture edge logic
	for (genvar i = 0; i < 2; i++) begin : g_ch
		tcc_channel #(
			.CW(CW)
		) u_ch (
			.clk_i     (CORE_CLK_I),
			.srst_i    (SRST_I),
			.enable_i  (ch_en[i]),
			.compare_i (is_cmp[i]),
			.action_i  (csc_r[i][CSC_EDGE_HI:CSC_EDGE_LO]),
			.tov_i     (csc_r[i][CSC_TOV]),
			.upd_i     (upd_r),
			.ovf_i     (ovf_pulse_r),
			.cnt_i     (cnt_r),
			.val_i     (ch_val[i]),
			.pin_i     (i == 0 ? CHAN0_PIN_I : CHAN1_PIN_I),
			.pin_o     (ch_pin[i]),
			.event_o   (ch_evt[i])
		);
	end

	// pin drivers; channel 1 lets go of its pin while linked
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			CHAN0_PIN_O    <= 1'b0;
			CHAN0_PIN_OE_O <= 1'b0;
			CHAN1_PIN_O    <= 1'b0;
			CHAN1_PIN_OE_O <= 1'b0;
		end else begin
			CHAN0_PIN_O    <= ch_pin[0];
			CHAN0_PIN_OE_O <= is_cmp[0];
			CHAN1_PIN_O    <= ch_pin[1];
			CHAN1_PIN_OE_O <= is_cmp[1] & ~linked;
		end
	end

	// linked pair bookkeeping: remember last written, swap on overflow
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I || !linked) begin
			buf_act_r  <= TCC_BUF_CH0;
			buf_last_r <= TCC_BUF_CH0;
		end else begin
			if (wr_en && PADDR_I == TCC_OFF_CVAL0) begin
				buf_last_r <= TCC_BUF_CH0;
			end else if (wr_en && PADDR_I == TCC_OFF_CVAL1) begin
				buf_last_r <= TCC_BUF_CH1;
			end
			// writing the active pair acts unbuffered, by design
			if (ovf_pulse_r) begin
				buf_act_r <= buf_last_r;
			end
		end
	end

	// timer status/control: select, stop, enable; modulo register
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			prescale_select_r <= TCC_PS_RST;
			stop_r            <= TCC_STOP_RST;
			ovf_ie_r          <= 1'b0;
			mod_r             <= TCC_MOD_RST;
		end else if (wr_en && PADDR_I == TCC_OFF_TSC) begin
			prescale_select_r <= PWDATA_I[2:0];
			stop_r            <= PWDATA_I[TSC_STOP];
			ovf_ie_r          <= PWDATA_I[TSC_OVF_IE];
		end else if (wr_en && PADDR_I == TCC_OFF_MOD) begin
			mod_r             <= PWDATA_I[CW-1:0];
		end
	end

	// overflow flag: cleared by writing zero, a new overflow wins
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			ovf_flag_r <= 1'b0;
		end else if (ovf_pulse_r) begin
			ovf_flag_r <= 1'b1;
		end else if (wr_en && PADDR_I == TCC_OFF_TSC &&
		             !PWDATA_I[TSC_OVF_FLAG]) begin
			ovf_flag_r <= 1'b0;
		end
	end

	// channel control and value registers; capture loads the value
	for (genvar i = 0; i < 2; i++) begin : g_reg
		localparam logic [7:0] OFF_CSC = i == 0 ? TCC_OFF_CSC0 : TCC_OFF_CSC1;
		localparam logic [7:0] OFF_VAL = i == 0 ? TCC_OFF_CVAL0 : TCC_OFF_CVAL1;

		always_ff @(posedge CORE_CLK_I) begin
			if (SRST_I) begin
				csc_r[i] <= 8'h00;
			end else if (wr_en && PADDR_I == OFF_CSC) begin
				// buffered select exists on channel 0 only
				csc_r[i] <= PWDATA_I[7:0] &
				            (i == 0 ? 8'h7e : 8'h5e);
			end
		end

		always_ff @(posedge CORE_CLK_I) begin
			if (SRST_I) begin
				cval_r[i] <= TCC_CVAL_RST;
			end else if (ch_evt[i] && !is_cmp[i]) begin
				cval_r[i] <= cnt_r;
			end else if (wr_en && PADDR_I == OFF_VAL) begin
				// a compare value is replaced at once
				cval_r[i] <= PWDATA_I[CW-1:0];
			end
		end

		// event flag: set on every event, set beats a zero write
		always_ff @(posedge CORE_CLK_I) begin
			if (SRST_I) begin
				ch_flag_r[i] <= 1'b0;
			end else if (ch_evt[i]) begin
				ch_flag_r[i] <= 1'b1;
			end else if (wr_en && PADDR_I == OFF_CSC &&
			             !PWDATA_I[CSC_FLAG]) begin
				ch_flag_r[i] <= 1'b0;
			end
		end
	end

	// interrupt requests gated by their enables
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			OVF_IRQ_O   <= 1'b0;
			CHAN0_IRQ_O <= 1'b0;
			CHAN1_IRQ_O <= 1'b0;
		end else begin
			OVF_IRQ_O   <= ovf_flag_r & ovf_ie_r;
			CHAN0_IRQ_O <= ch_flag_r[0] & csc_r[0][CSC_IE];
			CHAN1_IRQ_O <= ch_flag_r[1] & csc_r[1][CSC_IE] &
			               ~linked;
		end
	end

	// read mux; unmapped offsets read zero and flag an error
	always_comb begin
		rd_mux  = 32'h0000_0000;
		addr_ok = 1'b1;
		unique case (PADDR_I)
			TCC_OFF_TSC: rd_mux[7:0] = {ovf_flag_r, ovf_ie_r, stop_r,
			                            2'b00, prescale_select_r};
			TCC_OFF_CNT:   rd_mux[CW-1:0] = cnt_r;
			TCC_OFF_MOD:   rd_mux[CW-1:0] = mod_r;
			TCC_OFF_CSC0:  rd_mux[7:0] = {ch_flag_r[0], csc_r[0][6:0]};
			TCC_OFF_CVAL0: rd_mux[CW-1:0] = cval_r[0];
			TCC_OFF_CSC1:  rd_mux[7:0] = {ch_flag_r[1], csc_r[1][6:0]};
			TCC_OFF_CVAL1: rd_mux[CW-1:0] = cval_r[1];
			default:       addr_ok = 1'b0;
		endcase
	end

	// answer registered in setup, so every access has zero wait states
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
		end else begin
			PREADY_O  <= rd_setup;
			PSLVERR_O <= rd_setup & ~addr_ok;
			PRDATA_O  <= (rd_setup && !PWRITE_I) ? rd_mux : 32'h0000_0000;
		end
	end
endmodule

/* File: logic/tcc_pkg.sv */
package tcc_pkg;
	// apb byte offsets, one aligned word per register
	localparam logic [7:0] TCC_OFF_TSC   = 8'h00;
	localparam logic [7:0] TCC_OFF_CNT   = 8'h04;
	localparam logic [7:0] TCC_OFF_MOD   = 8'h08;
	localparam logic [7:0] TCC_OFF_CSC0  = 8'h0c;
	localparam logic [7:0] TCC_OFF_CVAL0 = 8'h10;
	localparam logic [7:0] TCC_OFF_CSC1  = 8'h14;
	localparam logic [7:0] TCC_OFF_CVAL1 = 8'h18;

	// timer status/control field positions
	localparam int TSC_OVF_FLAG  = 7;
	localparam int TSC_OVF_IE    = 6;
	localparam int TSC_STOP      = 5;
	localparam int TSC_CNT_RST   = 4;
	// channel status/control field positions
	localparam int CSC_FLAG      = 7;
	localparam int CSC_IE        = 6;
	localparam int CSC_BUF_SEL   = 5;
	localparam int CSC_UNBUF_SEL = 4;
	localparam int CSC_EDGE_HI   = 3;
	localparam int CSC_EDGE_LO   = 2;
	localparam int CSC_TOV       = 1;

	// values after reset
	localparam logic [15:0] TCC_MOD_RST  = 16'hffff;
	localparam logic [15:0] TCC_CVAL_RST = 16'h0000;
	localparam logic [2:0]  TCC_PS_RST   = 3'h0;
	localparam logic        TCC_STOP_RST = 1'b1;

	// prescale select code that picks the external clock pin
	localparam logic [2:0]  TCC_PS_EXT   = 3'h7;
	localparam int          TCC_PS_BITS  = 6;

	// edge or output action encodings of the two-bit edge field
	localparam logic [1:0] TCC_ACT_NONE  = 2'h0;
	localparam logic [1:0] TCC_ACT_RISE  = 2'h1;  // capture rising / toggle
	localparam logic [1:0] TCC_ACT_FALL  = 2'h2;  // capture falling / clear
	localparam logic [1:0] TCC_ACT_BOTH  = 2'h3;  // capture either / set

	// which linked register pair drives the buffered compare
	typedef enum logic [1:0] {
		TCC_BUF_CH0 = 2'b01,
		TCC_BUF_CH1 = 2'b10
	} tcc_buf_e;

	// a channel is output compare when either mode select is set
	function automatic logic tcc_is_compare(input logic buf_sel,
	                                        input logic unbuf_sel);
		tcc_is_compare = buf_sel | unbuf_sel;
	endfunction
endpackage

/* File: logic/tcc_prescaler.sv */
module tcc_prescaler
	import tcc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       clr_i,
	input  wire logic       run_i,
	input  wire logic [2:0] sel_i,
	input  wire logic       ext_clk_i,
	output logic            tick_o
);
	logic [TCC_PS_BITS-1:0] div_r;
	logic [2:0]             ext_sync_r;
	logic [TCC_PS_BITS-1:0] mask;

	// free divider; cleared with the counter so phases restart together
	always_ff @(posedge clk_i) begin
		if (srst_i || clr_i) begin
			div_r <= '0;
		end else if (run_i) begin
			div_r <= div_r + 1'b1;
		end
	end

	// pin is asynchronous: two flops, then a third for the edge
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ext_sync_r <= 3'h0;
		end else begin
			ext_sync_r <= {ext_sync_r[1:0], ext_clk_i};
		end
	end

	// divide by 2**sel: tick when the low sel bits are all ones
	assign mask = TCC_PS_BITS'((7'h1 << sel_i) - 7'h1);

	always_ff @(posedge clk_i) begin
		if (srst_i || clr_i || !run_i) begin
			tick_o <= 1'b0;
		end else if (sel_i == TCC_PS_EXT) begin
			tick_o <= ext_sync_r[1] & ~ext_sync_r[2];
		end else begin
			tick_o <= (div_r & mask) == mask;
		end
	end
endmodule

/* File: logic/tcc_channel.sv */
module tcc_channel
	import tcc_pkg::*;
#(
	parameter int CW = 16
) (
	input  wire logic          clk_i,
	input  wire logic          srst_i,
	input  wire logic          enable_i,
	input  wire logic          compare_i,
	input  wire logic [1:0]    action_i,
	input  wire logic          tov_i,
	input  wire logic          upd_i,
	input  wire logic          ovf_i,
	input  wire logic [CW-1:0] cnt_i,
	input  wire logic [CW-1:0] val_i,
	input  wire logic          pin_i,
	output logic               pin_o,
	output logic               event_o
);
	logic [2:0] pin_sync_r;
	logic       rise;
	logic       fall;
	logic       match;

	// two-flop synchroniser plus history for the edge detector
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_sync_r <= 3'h0;
		end else begin
			pin_sync_r <= {pin_sync_r[1:0], pin_i};
		end
	end

	assign rise  = pin_sync_r[1] & ~pin_sync_r[2];
	assign fall  = ~pin_sync_r[1] & pin_sync_r[2];
	// equality only: a value already passed gives no match this period
	assign match = upd_i && (cnt_i == val_i);

	// one pulse per capture edge, or per compare match with an action selected
	always_ff @(posedge clk_i) begin
		if (srst_i || !enable_i) begin
			event_o <= 1'b0;
		end else if (compare_i) begin
			event_o <= match && (action_i != TCC_ACT_NONE);
		end else begin
			unique case (action_i)
				TCC_ACT_RISE: event_o <= rise;
				TCC_ACT_FALL: event_o <= fall;
				TCC_ACT_BOTH: event_o <= rise | fall;
				default:      event_o <= 1'b0;
			endcase
		end
	end

	// pin drive: compare action, and optional toggle on overflow
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_o <= 1'b0;
		end else if (enable_i && compare_i) begin
			if (ovf_i && tov_i) begin
				pin_o <= ~pin_o;
			end else if (match) begin
				unique case (action_i)
					TCC_ACT_RISE: pin_o <= ~pin_o;
					TCC_ACT_FALL: pin_o <= 1'b0;
					TCC_ACT_BOTH: pin_o <= 1'b1;
					default:      pin_o <= pin_o;
				endcase
			end
		end
	end
endmodule

/* File: verif/tcc_checker.sv */
module tcc_checker
	import tcc_pkg::*;
#(
	parameter int CW = 16
) (
	input wire logic        CORE_CLK_I,
	input wire logic        SRST_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [7:0]  PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	input wire logic        CHAN0_PIN_OE_O,
	input wire logic        CHAN1_PIN_OE_O,
	input wire logic        OVF_IRQ_O,
	input wire logic        CHAN0_IRQ_O,
	input wire logic        CHAN1_IRQ_O
);
	logic wr_ok;
	logic ovf_ie_r;
	logic c0_ie_r;
	logic c1_ie_r;
	logic c0_cmp_r;
	logic link_r;

	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (SRST_I);

	// enable and mode bits as software last wrote them
	assign wr_ok = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			ovf_ie_r <= 1'b0;
			c0_ie_r  <= 1'b0;
			c1_ie_r  <= 1'b0;
			c0_cmp_r <= 1'b0;
			link_r   <= 1'b0;
		end else if (wr_ok) begin
			if (PADDR_I == TCC_OFF_TSC)
				ovf_ie_r <= PWDATA_I[TSC_OVF_IE];
			if (PADDR_I == TCC_OFF_CSC0) begin
				c0_ie_r  <= PWDATA_I[CSC_IE];
				c0_cmp_r <= PWDATA_I[CSC_BUF_SEL] | PWDATA_I[CSC_UNBUF_SEL];
				link_r   <= PWDATA_I[CSC_BUF_SEL];
			end
			if (PADDR_I == TCC_OFF_CSC1)
				c1_ie_r <= PWDATA_I[CSC_IE];
		end
	end

	// bus steps
	sequence s_setup;
		PSEL_I && !PENABLE_I;
	endsequence
	sequence s_bad_setup;
		s_setup ##0 (PADDR_I > TCC_OFF_CVAL1 || PADDR_I[1:0] != 2'h0);
	endsequence

	a_ready_after_setup: assert property (s_setup |=> PREADY_O)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready held too long");
	a_rdata_idle_zero: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
		else $error("read data outside access");
	a_unmapped_refused: assert property (s_bad_setup |=>
		PSLVERR_O && PRDATA_O == 32'h0)
		else $error("unmapped access not refused");
	a_cnt_read_ok: assert property (
		s_setup ##0 (PADDR_I == TCC_OFF_CNT) |=> !PSLVERR_O)
		else $error("counter read refused");
	a_ovf_irq_masked: assert property (!ovf_ie_r [*2] |-> !OVF_IRQ_O)
		else $error("overflow request while disabled");
	a_ch0_irq_masked: assert property (!c0_ie_r [*2] |-> !CHAN0_IRQ_O)
		else $error("channel 0 request while disabled");
	a_ch1_irq_masked: assert property (
		(!c1_ie_r || link_r) [*2] |-> !CHAN1_IRQ_O)
		else $error("channel 1 request while off");
	a_ch1_released: assert property (link_r [*3] |-> !CHAN1_PIN_OE_O)
		else $error("channel 1 pin driven while linked");
	a_ch0_oe_compare: assert property (c0_cmp_r [*3] |-> CHAN0_PIN_OE_O)
		else $error("compare pin not driven");
	a_ch0_oe_capture: assert property (!c0_cmp_r [*3] |-> !CHAN0_PIN_OE_O)
		else $error("capture pin driven");
endmodule

/* File: verif/tcc_pins_model.sv */
module tcc_pins_model (
	input  wire logic       clk_i,
	input  wire logic       ext_run_i,
	input  wire logic [1:0] src_i,
	input  wire logic [1:0] oe_i,
	input  wire logic [1:0] out_i,
	output logic      [1:0] pin_o,
	output logic            ext_clk_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div_r = 2'h0;
	logic       ext_r = 1'b0;

	// external count source, eight core cycles a period, low when off
	always @(posedge clk_i) begin
		div_r <= div_r + 2'h1;
		if (!ext_run_i)
			ext_r <= 1'b0;
		else if (div_r == 2'h3)
			ext_r <= ~ext_r;
	end
	assign ext_clk_o = ext_r;
	// the timer owns the wire while enabled, else the event source
	assign pin_o = (oe_i & out_i) | (~oe_i & src_i);
endmodule

/* File: verif/tcc_timer_tb_top.sv */
module tcc_timer_tb_top
	import tcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ext_run = 1'b0;
	logic        ext_clk;
	logic [1:0]  src = 2'h0;
	logic [1:0]  pin;
	logic [1:0]  oe;
	logic [1:0]  out;
	logic [2:0]  irq;
	logic [31:0] q;
	logic [31:0] c1;
	logic        err;
	logic        hit;
	int          per;
	int          miscompares = 0;
	int          num_checks = 0;
	logic [31:0] rv [7] = '{32'h20, 0, 32'hffff, 0, 0, 0, 0};
	logic [31:0] cm [4] = '{32'h1c, 32'h18, 32'h14, 32'h12};
	logic [1:0]  md [4] = '{2'h1, 2'h0, 2'h2, 2'h2};
	logic        fl [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

	tcc_timer #(.CW(16)) tcc_timer_inst (
		.CORE_CLK_I(clk), .SRST_I(srst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .EXT_TIMER_CLOCK_PIN_I(ext_clk),
		.CHAN0_PIN_I(pin[0]), .CHAN0_PIN_O(out[0]),
		.CHAN0_PIN_OE_O(oe[0]), .CHAN1_PIN_I(pin[1]),
		.CHAN1_PIN_O(out[1]), .CHAN1_PIN_OE_O(oe[1]),
		.OVF_IRQ_O(irq[0]), .CHAN0_IRQ_O(irq[1]), .CHAN1_IRQ_O(irq[2])
	);
	tcc_pins_model tcc_pins_model_inst (
		.clk_i(clk), .ext_run_i(ext_run), .src_i(src), .oe_i(oe),
		.out_i(out), .pin_o(pin), .ext_clk_o(ext_clk)
	);

	// core clock, 40 ns period
	initial begin
		forever #20 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// one transfer; held until pready is sampled high, no bus release
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
	endtask

	task automatic idle(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	// channel 0 pin now and one ten-cycle period later
	task automatic pintog(input logic t);
		logic c;
		c = out[0];
		idle(10);
		chk(32'(out[0]), 32'(c ^ t));
	endtask

	// hang guard, far beyond the twelve hundred or so cycles needed
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		test_done();
	end

	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		ext_run <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk(q, rv[i]);
		end
		apb(1'b0, 8'h1c, 32'h0);
		chk({q[30:0], err}, 32'h1);
		idle(2);
		$display("test map done");
		// four ticks per window at every rate, reads never stall it
		for (int p = 0; p < 8; p++) begin
			per = (p == 7) ? 8 : (1 << p);
			apb(1'b1, TCC_OFF_TSC, 32'(p));
			idle(4);
			apb(1'b0, TCC_OFF_CNT, 32'h0);
			c1 = q;
			idle(4 * per - 2);
			apb(1'b0, TCC_OFF_CNT, 32'h0);
			chk(32'(q[15:0] - c1[15:0]), 32'h4);
		end
		idle(2);
		$display("test rates done");
		// modulo 9 gives a ten-cycle period
		apb(1'b1, TCC_OFF_TSC, 32'h30);
		apb(1'b1, TCC_OFF_MOD, 32'h9);
		apb(1'b1, TCC_OFF_TSC, 32'h40);
		idle(30);
		apb(1'b0, TCC_OFF_CNT, 32'h0);
		c1 = q;
		chk(32'(c1 <= 32'h9), 32'h1);
		idle(8);
		apb(1'b0, TCC_OFF_CNT, 32'h0);
		chk(q, c1);
		apb(1'b0, TCC_OFF_TSC, 32'h0);
		chk(q, 32'hc0);
		chk(32'(irq[0]), 32'h1);
		apb(1'b1, TCC_OFF_TSC, 32'h20);
		idle(3);
		chk(32'(irq[0]), 32'h0);
		apb(1'b0, TCC_OFF_CNT, 32'h0);
		c1 = q;
		idle(6);
		apb(1'b0, TCC_OFF_CNT, 32'h0);
		chk(q, c1);
		apb(1'b1, TCC_OFF_TSC, 32'h30);
		apb(1'b0, TCC_OFF_CNT, 32'h0);
		chk(q, 32'h0);
		idle(2);
		$display("test modulo done");
		// capture on channel 1 with the counter parked at a known value
		apb(1'b1, TCC_OFF_MOD, 32'hffff);
		apb(1'b1, TCC_OFF_TSC, 32'h0);
		idle(23);
		apb(1'b1, TCC_OFF_TSC, 32'h20);
		apb(1'b0, TCC_OFF_CNT, 32'h0);
		c1 = q;
		for (int k = 1; k < 4; k++) begin
			for (int e = 0; e < 2; e++) begin
				hit = e ? k[1] : k[0];
				apb(1'b1, TCC_OFF_CVAL1, 32'h0);
				apb(1'b1, TCC_OFF_CSC1, 32'h40 | 32'(k << 2));
				idle(2);
				src[1] <= ~src[1];
				idle(10);
				apb(1'b0, TCC_OFF_CSC1, 32'h0);
				chk(32'(q[7]), 32'(hit));
				chk(32'(irq[2]), 32'(hit));
				apb(1'b0, TCC_OFF_CVAL1, 32'h0);
				chk(q, hit ? c1 : 32'h0);
			end
		end
		idle(2);
		$display("test capture done");
		// channel 0 compares at 4 within the ten-cycle period
		apb(1'b1, TCC_OFF_MOD, 32'h9);
		apb(1'b1, TCC_OFF_CVAL0, 32'h4);
		apb(1'b1, TCC_OFF_TSC, 32'h10);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, TCC_OFF_CSC0, cm[i]);
			idle(25);
			apb(1'b0, TCC_OFF_CSC0, 32'h0);
			chk(32'(q[7]), 32'(fl[i]));
			pintog(md[i][1]);
			// toggle phase depends on the period; there check the drive
			chk(32'(md[i][1] ? oe[0] : out[0]), 32'(md[i][0] | md[i][1]));
		end
		apb(1'b1, TCC_OFF_CVAL0, 32'hc);
		apb(1'b1, TCC_OFF_CSC0, 32'h18);
		idle(25);
		apb(1'b0, TCC_OFF_CSC0, 32'h0);
		chk(32'(q[7]), 32'h0);
		$display("test compare done");
		// linked pair: channel 0 first, then whichever was written last
		apb(1'b1, TCC_OFF_CVAL0, 32'h3);
		apb(1'b1, TCC_OFF_CSC0, 32'h34);
		apb(1'b1, TCC_OFF_CSC1, 32'h50);
		idle(25);
		pintog(1'b1);
		chk({30'h0, oe[1], irq[2]}, 32'h0);
		apb(1'b0, TCC_OFF_CSC0, 32'h0);
		chk(32'(q[7]), 32'h1);
		apb(1'b1, TCC_OFF_CVAL1, 32'hc);
		idle(25);
		pintog(1'b0);
		apb(1'b1, TCC_OFF_CVAL0, 32'h5);
		idle(25);
		pintog(1'b1);
		$display("test linked done");
		test_done();
	end
endmodule

bind tcc_timer tcc_checker #(.CW(CW)) tcc_checker_inst (.*);
